// *** logic/p1sc_counters.sv ***
// Port 1 transmit statistics counters with snapshot-on-read, behind a Wishbone slave

// Contract
// [RULE1] Keep four separate 16-bit counters: frames, bad frames, lines, bad lines.
// [RULE2] Bad-frame high read returns counter bits 15:8 as they stand.
// [RULE3] Same read copies bits 7:0 into bad-frame low register and zeroes counter.
// [RULE4] Bad-frame low read returns captured bits 7:0, no effect on counter.
// [RULE5] Software reads bad-frame high before bad-frame low.
// [RULE6] Line high read returns bits 15:8, captures low byte, zeroes counter.
// [RULE7] Line low read returns bits 7:0 captured by preceding high read.
// [RULE8] Software reads line high first, then line low.
// [RULE9] Bad-line high read returns bits 15:8, captures low byte, zeroes counter.
// [RULE10] Bad-line low read returns bits 7:0 captured by last high read.
// [RULE11] Software reads bad-line high ahead of bad-line low.
// [RULE12] Frame low read returns bits 7:0 captured by preceding frame high read.
// [RULE13] Software reads frame high before frame low.
// [RULE14] Frame high read returns bits 15:8, captures low byte, zeroes counter.
// [RULE15] Counters step once per sent frame or line; error counters only when flagged.
// [RULE16] Snapshots hold until next high read; counting continues after the clear.
module p1sc_counters
  import p1sc_pkg::*;
(
  input  wire logic        clk_i,      // 125 MHz clock
  input  wire logic        rst_i,      // Synchronous reset, active high
  input  wire logic        wb_cyc_i,   // Bus cycle
  input  wire logic        wb_stb_i,   // Bus strobe
  input  wire logic        wb_we_i,    // Write enable
  input  wire logic [31:0] wb_adr_i,   // Byte address
  input  wire logic [3:0]  wb_sel_i,   // Byte lane selects
  input  wire logic [31:0] wb_dat_i,   // Write data
  output logic      [31:0] wb_dat_o,   // Read data
  output logic             wb_ack_o,   // Acknowledge
  input  wire p1sc_evt_s   tx_evt_i,   // Port 1 transmit events
  output logic             irq_o       // Level interrupt
);

  p1sc_state_s      s_r;
  p1sc_state_s      s_nxt;
  logic [3:0]       inc;
  logic             take;
  logic             hit;
  logic             rd;
  logic             wr;
  logic [7:0]       idx;
  logic [31:0]      rd_val;
  logic [3:0]       wrap;

  // Counting qualifiers per slot
  assign inc[P1SC_SLOT_FRAME]     = tx_evt_i.frame_sent;                       // see [RULE15]
  assign inc[P1SC_SLOT_BAD_FRAME] = tx_evt_i.frame_sent & tx_evt_i.frame_bad;  // see [RULE15]
  assign inc[P1SC_SLOT_LINE]      = tx_evt_i.line_sent;                        // see [RULE15]
  assign inc[P1SC_SLOT_BAD_LINE]  = tx_evt_i.line_sent & tx_evt_i.line_bad;    // see [RULE15]

  // Request taken once; the ack cycle itself is not a new request
  assign take = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign idx  = wb_adr_i[P1SC_ADR_LSB +: P1SC_IDX_W];
  assign hit  = take & (wb_adr_i[P1SC_ADR_W-1:P1SC_ADR_LSB+P1SC_IDX_W] == '0);
  assign rd   = hit & ~wb_we_i;
  assign wr   = hit & wb_we_i;

  always_comb begin
    s_nxt  = s_r;
    rd_val = P1SC_DAT_RST;
    wrap   = 4'h0;
    s_nxt.ack = take;

    for (int i = 0; i < P1SC_NUM_CNT; i++) begin
      // High-byte read: report MSBs, snapshot LSBs, clear
      if (idx == P1SC_IDX_HIGH[i]) begin
        rd_val = {24'h000000, s_r.cnt[i][15:8]};  // see [RULE2] [RULE6] [RULE9] [RULE14]
        if (rd) begin
          s_nxt.low[i] = s_r.cnt[i][7:0];        // see [RULE3] [RULE6] [RULE9] [RULE14]
          s_nxt.cnt[i] = P1SC_CNT_RST;           // see [RULE3] [RULE16]
        end
      end
      // Low-byte read returns the snapshot only
      if (idx == P1SC_IDX_LOW[i]) begin
        rd_val = {24'h000000, s_r.low[i]};      // see [RULE4] [RULE7] [RULE10] [RULE12]
      end
      // An event in the clearing cycle still counts
      if (inc[i]) begin
        wrap[i]      = (s_nxt.cnt[i] == P1SC_CNT_MAX);
        s_nxt.cnt[i] = s_nxt.cnt[i] + P1SC_CNT_ONE;  // see [RULE1] [RULE15] [RULE16]
      end
    end

    if (idx == P1SC_IDX_IRQ_STATUS) begin
      rd_val = {28'h0000000, s_r.sts};
    end
    if (idx == P1SC_IDX_IRQ_MASK) begin
      rd_val = {28'h0000000, s_r.msk};
    end

    // Status clears on read; a wrap in the same cycle wins
    if (rd && idx == P1SC_IDX_IRQ_STATUS) begin
      s_nxt.sts = P1SC_STS_RST;
    end
    s_nxt.sts = s_nxt.sts | wrap;

    if (wr && idx == P1SC_IDX_IRQ_MASK && wb_sel_i[0]) begin
      s_nxt.msk = wb_dat_i[3:0];
    end

    // Unmapped or written addresses answer with zero data
    if (take) begin
      s_nxt.dat = rd ? rd_val : P1SC_DAT_RST;
    end

    s_nxt.irq = |(s_nxt.sts & s_nxt.msk);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r.cnt <= {P1SC_CNT_RST, P1SC_CNT_RST, P1SC_CNT_RST, P1SC_CNT_RST};
      s_r.low <= {P1SC_LOW_RST, P1SC_LOW_RST, P1SC_LOW_RST, P1SC_LOW_RST};
      s_r.sts <= P1SC_STS_RST;
      s_r.msk <= P1SC_MSK_RST;
      s_r.ack <= 1'b0;
      s_r.dat <= P1SC_DAT_RST;
      s_r.irq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign irq_o    = s_r.irq;

endmodule : p1sc_counters

// *** pkg/p1sc_pkg.sv ***
// Package for the port 1 statistics counter bank: register indices, layouts, reset values
package p1sc_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [7:0] P1SC_IDX_FRAME_HIGH    = 8'h98;
  localparam logic [7:0] P1SC_IDX_FRAME_LOW     = 8'h99;
  localparam logic [7:0] P1SC_IDX_BAD_FRAME_HIGH = 8'h9a;
  localparam logic [7:0] P1SC_IDX_BAD_FRAME_LOW = 8'h9b;
  localparam logic [7:0] P1SC_IDX_LINE_HIGH     = 8'h9c;
  localparam logic [7:0] P1SC_IDX_LINE_LOW      = 8'h9d;
  localparam logic [7:0] P1SC_IDX_BAD_LINE_HIGH = 8'h9e;
  localparam logic [7:0] P1SC_IDX_BAD_LINE_LOW  = 8'h9f;
  localparam logic [7:0] P1SC_IDX_IRQ_STATUS    = 8'hc0;
  localparam logic [7:0] P1SC_IDX_IRQ_MASK      = 8'hc1;

  // Address layout
  localparam int unsigned P1SC_ADR_LSB = 2;
  localparam int unsigned P1SC_IDX_W   = 8;
  localparam int unsigned P1SC_ADR_W   = 32;
  localparam int unsigned P1SC_DAT_W   = 32;

  // Counter slots, in status and mask bit order
  localparam int unsigned P1SC_NUM_CNT   = 4;
  localparam int unsigned P1SC_CNT_W     = 16;
  localparam int unsigned P1SC_BYTE_W    = 8;
  localparam int unsigned P1SC_SLOT_FRAME     = 0;
  localparam int unsigned P1SC_SLOT_BAD_FRAME = 1;
  localparam int unsigned P1SC_SLOT_LINE      = 2;
  localparam int unsigned P1SC_SLOT_BAD_LINE  = 3;

  localparam logic [3:0][7:0] P1SC_IDX_HIGH = {P1SC_IDX_BAD_LINE_HIGH, P1SC_IDX_LINE_HIGH,
                                               P1SC_IDX_BAD_FRAME_HIGH, P1SC_IDX_FRAME_HIGH};
  localparam logic [3:0][7:0] P1SC_IDX_LOW  = {P1SC_IDX_BAD_LINE_LOW, P1SC_IDX_LINE_LOW,
                                               P1SC_IDX_BAD_FRAME_LOW, P1SC_IDX_FRAME_LOW};

  // Reset values, counter wrap limit and increment
  localparam logic [15:0] P1SC_CNT_RST  = 16'h0000;
  localparam logic [15:0] P1SC_CNT_MAX  = 16'hffff;
  localparam logic [15:0] P1SC_CNT_ONE  = 16'h0001;
  localparam logic [7:0]  P1SC_LOW_RST  = 8'h00;
  localparam logic [3:0]  P1SC_STS_RST  = 4'h0;
  localparam logic [3:0]  P1SC_MSK_RST  = 4'h0;
  localparam logic [31:0] P1SC_DAT_RST  = 32'h0000_0000;

  // Transmit events from output port 1, one-cycle pulses
  typedef struct packed {
    logic line_bad;     // Line just sent carried an error
    logic line_sent;    // A line was sent
    logic frame_bad;    // Frame just sent carried an error
    logic frame_sent;   // A frame was sent
  } p1sc_evt_s;

  // Whole state of the counter bank
  typedef struct packed {
    logic [3:0][15:0] cnt;   // Live counters
    logic [3:0][7:0]  low;   // Low-byte snapshots
    logic [3:0]       sts;   // Sticky wrap flags
    logic [3:0]       msk;   // Interrupt enables
    logic             ack;   // Bus acknowledge
    logic [31:0]      dat;   // Bus read data
    logic             irq;   // Interrupt output
  } p1sc_state_s;

endpackage : p1sc_pkg

// *** dv/p1sc_counters_checker.sv ***
// Bus and reset assertions for the port 1 statistics counter bank
module p1sc_counters_checker
  import p1sc_pkg::*;
(
  input wire logic        clk_i,    // Clock
  input wire logic        rst_i,    // Reset
  input wire logic        wb_cyc_i, // Cycle
  input wire logic        wb_stb_i, // Strobe
  input wire logic        wb_we_i,  // Write
  input wire logic [31:0] wb_adr_i, // Address
  input wire logic [3:0]  wb_sel_i, // Selects
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic        wb_ack_o, // Ack
  input wire p1sc_evt_s   tx_evt_i, // Events
  input wire logic        irq_o     // Interrupt
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tk;
  logic cr;
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign cr = (wb_adr_i[31:10] == 22'h0) && (wb_adr_i[9:5] == 5'h13);
  ack_answer_a: assert property (tk |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(tk))
    else $error("ack without request");
  data_hold_a: assert property (!$past(tk) |-> $stable(wb_dat_o))
    else $error("read data moved");
  byte_only_a: assert property (tk && !wb_we_i && cr |=> wb_dat_o[31:8] == 24'h0)
    else $error("counter read wider than a byte");
  unmapped_zero_a: assert property (tk && wb_adr_i[31:10] != 22'h0 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  write_zero_a: assert property (tk && wb_we_i && cr |=> wb_dat_o == 32'h0)
    else $error("counter write returned data");
  reset_clear_a: assert property ($past(rst_i) |-> !wb_ack_o && !irq_o && wb_dat_o == 32'h0)
    else $error("outputs not cleared by reset");
endmodule : p1sc_counters_checker

bind p1sc_counters p1sc_counters_checker i_chk (.*);

// *** dv/p1sc_counters_tb_top.sv ***
// Self-checking bench for the port 1 statistics counter bank
module p1sc_counters_tb_top import p1sc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq;
  logic [31:0] adr = 0, dw = 0, dr;
  logic [3:0]  sel = 4'hf;
  p1sc_evt_s   ev = '0;
  int          n_mismatch = 0, total_checks = 0;
  always #4 clk_i = ~clk_i;
  p1sc_counters i_p1sc_counters (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .tx_evt_i(ev), .irq_o(irq));
  task automatic chk(input string n, input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop;
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dr;
    cyc <= 0;
    stb <= 0;
    @(posedge clk_i);
  endtask : bus
  task automatic pair(input int s, input logic [15:0] x);
    logic [31:0] q;
    bus(0, {22'h0, P1SC_IDX_HIGH[s], 2'b00}, 0, q);
    chk("high", q, {24'h0, x[15:8]});
    repeat (2) begin
      bus(0, {22'h0, P1SC_IDX_LOW[s], 2'b00}, 0, q);
      chk("low", q, {24'h0, x[7:0]});
    end
  endtask : pair
  task automatic all4(input logic [3:0][15:0] x);
    for (int s = 0; s < 4; s++) pair(s, x[s]);
  endtask : all4
  task automatic evt(input p1sc_evt_s e, input int n);
    ev <= e;
    repeat (n) @(posedge clk_i);
    ev <= '0;
    @(posedge clk_i);
  endtask : evt
  task automatic t_counts;
    logic [31:0] q;
    all4('0);
    evt(4'b0001, 'h123);
    evt(4'b0011, 5);
    evt(4'b0010, 3);
    evt(4'b0100, 'h210);
    evt(4'b1100, 7);
    evt(4'b1000, 2);
    bus(1, 32'h260, 32'hff, q);
    chk("counter write data", q, 32'h0);
    all4({16'h7, 16'h217, 16'h5, 16'h128});
    all4('0);
    evt(4'b0101, 1);
    all4({16'h0, 16'h1, 16'h0, 16'h1});
  endtask : t_counts
  task automatic t_irq;
    logic [31:0] q;
    bus(0, 32'h400, 0, q);
    chk("unmapped", q, 32'h0);
    evt(4'b0001, 'h10000);
    chk("irq masked", {31'h0, irq}, 32'h0);
    sel <= 4'h0;
    bus(1, 32'h304, 32'h1, q);
    chk("irq sel off", {31'h0, irq}, 32'h0);
    sel <= 4'hf;
    bus(1, 32'h304, 32'h1, q);
    chk("irq raised", {31'h0, irq}, 32'h1);
    bus(0, 32'h300, 0, q);
    chk("status", q, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    pair(0, 16'h0);
  endtask : t_irq
  initial begin
    repeat (80000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_counts;
    t_irq;
    report_and_stop;
  end
endmodule : p1sc_counters_tb_top
